// file: design/tws_pkg.sv
// Purpose: shared constants of the two-wire master status and irq block
// Assumes: 32-bit register bus, byte addresses, word aligned registers
// Notes:   bit positions are shared by status, mask and clear registers
package tws_pkg;
    localparam int          ADDR_W         = 6;
    localparam int          DATA_W         = 32;
    localparam int          BE_W           = 4;

    // register byte offsets
    localparam logic [5:0]  OFS_STATUS     = 6'h1C;
    localparam logic [5:0]  OFS_IRQ_SET    = 6'h20;
    localparam logic [5:0]  OFS_IRQ_CLR    = 6'h24;
    localparam logic [5:0]  OFS_IRQ_MASK   = 6'h28;
    localparam logic [5:0]  OFS_STAT_CLR   = 6'h2C;
    localparam logic [5:0]  OFS_PARAMS     = 6'h30;
    localparam logic [5:0]  OFS_REVISION   = 6'h34;

    // status bit positions
    localparam int          B_RX_READY     = 0;
    localparam int          B_TX_READY     = 1;
    localparam int          B_CMD_READY    = 2;
    localparam int          B_CMD_DONE     = 3;
    localparam int          B_IDLE         = 4;
    localparam int          B_BUS_FREE     = 5;
    localparam int          B_ADDR_NAK     = 8;
    localparam int          B_DATA_NAK     = 9;
    localparam int          B_ARB_LOST     = 10;
    localparam int          B_ALERT        = 11;
    localparam int          B_TIMEOUT      = 12;
    localparam int          B_PEC_ERR      = 13;
    localparam int          B_STOP_ACC     = 14;
    localparam int          B_MASTER_EN    = 16;

    // bits that exist in the mask, and those software may clear
    localparam logic [31:0] MASK_BITS      = 32'h0000_7F3F;
    localparam logic [31:0] CLEARABLE_BITS = 32'h0000_7F08;

    // revision field layout
    localparam int          VER_LSB        = 0;
    localparam int          VER_W          = 12;
    localparam int          VAR_LSB        = 16;
    localparam int          VAR_W          = 4;

    // reset values
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    localparam logic [31:0] PARAMS_VALUE   = 32'h0000_0000;

    // bus slave phases
    typedef enum logic [0:0] {
        TWS_WAIT = 1'b0,
        TWS_ACK  = 1'b1
    } tws_phase_t;
endpackage : tws_pkg

// file: design/tws_master_status.sv
// Purpose: status flags, interrupt mask and irq of a two-wire bus master
// Assumes: engine strobes on i_core_clk; bus pins arrive asynchronously
// Notes:   one instance per master, each on its own bus-interface clock
// Contract
// - set arbitration lost on data line mismatch
// - set data nak flag, cleared by write
// - set address nak flag, cleared by write
// - bus free high when bus activity completed
// - idle only with no command running or queued
// - command complete only on success, write clears
// - command ready while active or queued slot free
// - tx ready while holding register accepts bytes
// - rx ready while unread byte is held
// - enable-set write ones set mask bits
// - enable-clear write ones clear mask bits
// - mask resets to zero, one enables interrupt
// - clear write drops flag and its request
// - revision holds version and variant fields
// - parameter register reads all zeros
// - each master on its own interface clock
// - set stop accepted flag, cleared by write
// - timeout, pec error and alert flags set
`timescale 1ns/1ps
module tws_master_status
    import tws_pkg::*;
#(
    parameter logic [11:0] VERSION_NUM = 12'hA5C,   // arbitrary value
    parameter logic [3:0]  VARIANT_NUM = 4'h3       // arbitrary value
) (
    input  wire logic                       i_core_clk,     // interface clock
    input  wire logic                       i_rst,          // async, high
    // register bus, avalon-mm slave
    input  wire logic [tws_pkg::ADDR_W-1:0] i_avs_address,  // byte address
    input  wire logic                       i_avs_read,     // read request
    input  wire logic                       i_avs_write,    // write request
    input  wire logic [tws_pkg::DATA_W-1:0] i_avs_writedata,// write data
    input  wire logic [tws_pkg::BE_W-1:0]   i_avs_byteenable,// write lanes
    output logic      [tws_pkg::DATA_W-1:0] o_avs_readdata, // read data
    output logic                            o_avs_waitrequest,// stall
    // two-wire pins, asynchronous
    input  wire logic                       i_scl_pin,      // clock line
    input  wire logic                       i_sda_pin,      // data line
    // engine, same clock
    input  wire logic                       i_sda_drive_low,// engine pulls low
    input  wire logic                       i_bus_owner,    // engine transmits
    input  wire logic                       i_master_en,    // interface on
    input  wire logic                       i_addr_nak,     // pulse
    input  wire logic                       i_data_nak,     // pulse
    input  wire logic                       i_cmd_ok,       // pulse, success
    input  wire logic                       i_stop_acc,     // pulse
    input  wire logic                       i_timeout,      // pulse
    input  wire logic                       i_pec_err,      // pulse
    input  wire logic                       i_alert,        // pulse
    input  wire logic                       i_cmd_busy,     // command running
    input  wire logic                       i_cmd_valid,    // active slot full
    input  wire logic                       i_ncmd_valid,   // queued slot full
    input  wire logic                       i_tx_full,      // tx holding full
    input  wire logic                       i_tx_stopped,   // tx halted
    input  wire logic                       i_rx_avail,     // rx byte unread
    output logic                            o_irq           // level irq
);
    import tws_pkg::*;

    // pin synchronisers; the first stage feeds only the second
    logic [1:0]  scl_sync_ff;
    logic [1:0]  sda_sync_ff;
    logic        scl_prev_ff;
    logic        sda_prev_ff;
    logic        bus_free_ff;
    logic [31:0] sticky_ff;
    logic [31:0] level_ff;
    logic [31:0] mask_ff;
    logic [31:0] status;
    logic [31:0] nxt_sticky;
    logic [31:0] nxt_mask;
    logic [31:0] set_evt;
    logic [31:0] clr_req;
    logic [31:0] wr_bits;
    logic [31:0] rd_value;
    logic        scl_rise;
    logic        start_seen;
    logic        stop_seen;
    logic        arb_mismatch;
    logic        wr_take;
    tws_phase_t  phase_ff;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], i_scl_pin};
            sda_sync_ff <= {sda_sync_ff[0], i_sda_pin};
        end
    end

    // one cycle history of the synchronised lines, for edge finding
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    // line events; start and stop need the clock line high
    assign scl_rise   = scl_sync_ff[1] & ~scl_prev_ff;
    assign start_seen = scl_sync_ff[1] & scl_prev_ff
                        & sda_prev_ff & ~sda_sync_ff[1];
    assign stop_seen  = scl_sync_ff[1] & scl_prev_ff
                        & ~sda_prev_ff & sda_sync_ff[1];

    // sampled on the clock rise, when data must be stable; a released
    // line that reads low means another master is pulling it
    assign arb_mismatch = i_bus_owner & scl_rise & ~i_sda_drive_low
                          & ~sda_sync_ff[1];

    // free after a stop, busy from a start; free out of reset
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_free_ff <= 1'b1;
        end else if (stop_seen) begin
            bus_free_ff <= 1'b1;
        end else if (start_seen) begin
            bus_free_ff <= 1'b0;
        end
    end

    // level flags follow the engine and the bus lines, no software action needed
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            level_ff <= RST_ZERO;
            level_ff[B_CMD_READY] <= 1'b1;
        end else begin
            level_ff <= RST_ZERO;
            level_ff[B_RX_READY]  <= i_rx_avail;
            level_ff[B_TX_READY]  <= ~i_tx_full
                                     & ~i_tx_stopped;
            level_ff[B_CMD_READY] <= ~(i_cmd_valid
                                       & i_ncmd_valid);
            level_ff[B_IDLE]      <= ~i_cmd_busy & ~i_cmd_valid
                                     & ~i_ncmd_valid;
            level_ff[B_BUS_FREE]  <= bus_free_ff;
            level_ff[B_MASTER_EN] <= i_master_en;
        end
    end

    // event strobes gathered at their status positions
    always_comb begin
        set_evt = RST_ZERO;
        set_evt[B_ARB_LOST] = arb_mismatch;
        set_evt[B_DATA_NAK] = i_data_nak;
        set_evt[B_ADDR_NAK] = i_addr_nak;
        set_evt[B_CMD_DONE] = i_cmd_ok;
        set_evt[B_STOP_ACC] = i_stop_acc;
        set_evt[B_TIMEOUT]  = i_timeout;
        set_evt[B_PEC_ERR]  = i_pec_err;
        set_evt[B_ALERT]    = i_alert;
    end

    // write data masked by byte lanes
    generate
        for (genvar g = 0; g < BE_W; g++) begin : g_lane
            assign wr_bits[g*8 +: 8] = i_avs_writedata[g*8 +: 8]
                                       & {8{i_avs_byteenable[g]}};
        end
    endgenerate

    // a write takes effect only at the edge where waitrequest is sampled low, one cycle after its stall ends
    assign wr_take = i_avs_write & (phase_ff == TWS_ACK);
    assign clr_req = (wr_take && i_avs_address == OFS_STAT_CLR)
                     ? (wr_bits & CLEARABLE_BITS) : RST_ZERO;

    // an event in the clearing cycle survives: set beats clear
    assign nxt_sticky = (sticky_ff & ~clr_req) | set_evt;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sticky_ff <= RST_ZERO;
        end else begin
            sticky_ff <= nxt_sticky;
        end
    end

    // mask set and clear; only implemented status bits are kept
    always_comb begin
        nxt_mask = mask_ff;
        if (wr_take) begin
            if (i_avs_address == OFS_IRQ_SET) begin
                nxt_mask = mask_ff | (wr_bits & MASK_BITS);
            end else if (i_avs_address == OFS_IRQ_CLR) begin
                nxt_mask = mask_ff & ~wr_bits;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_ff <= RST_ZERO;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    assign status = sticky_ff | level_ff;

    // irq from the next state, so clearing drops it at once
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((nxt_sticky | level_ff) & nxt_mask);
        end
    end

    // read mux; unmapped and write-only offsets read as zero
    always_comb begin
        rd_value = RST_ZERO;
        if (i_avs_address == OFS_STATUS) begin
            rd_value = status;
        end else if (i_avs_address == OFS_IRQ_MASK) begin
            rd_value = mask_ff;
        end else if (i_avs_address == OFS_PARAMS) begin
            rd_value = PARAMS_VALUE;
        end else if (i_avs_address == OFS_REVISION) begin
            rd_value[VER_LSB +: VER_W] = VERSION_NUM;
            rd_value[VAR_LSB +: VAR_W] = VARIANT_NUM;
        end
    end

    // one stall cycle per access keeps read data registered
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_ff          <= TWS_WAIT;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= RST_ZERO;
        end else begin
            case (phase_ff)
                TWS_WAIT: begin
                    if (i_avs_read | i_avs_write) begin
                        phase_ff          <= TWS_ACK;
                        o_avs_waitrequest <= 1'b0;
                        o_avs_readdata    <= rd_value;
                    end
                end
                TWS_ACK: begin
                    phase_ff          <= TWS_WAIT;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    phase_ff          <= TWS_WAIT;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // each master instance runs on its own i_core_clk
endmodule : tws_master_status

// file: tb/tws_status_sva.sv
// Purpose: port checks for the status and irq block
// Assumes: one clock domain, asynchronous high reset
// Notes:   mask shadow honours byte lanes like the design does
`timescale 1ns/1ps
module tws_status_sva
    import tws_pkg::*;
(
    input wire logic                       i_core_clk,        // clock
    input wire logic                       i_rst,             // reset
    input wire logic [tws_pkg::ADDR_W-1:0] i_avs_address,     // address
    input wire logic                       i_avs_read,        // read
    input wire logic                       i_avs_write,       // write
    input wire logic [tws_pkg::DATA_W-1:0] i_avs_writedata,   // data in
    input wire logic [tws_pkg::BE_W-1:0]   i_avs_byteenable,  // lanes
    input wire logic [tws_pkg::DATA_W-1:0] o_avs_readdata,    // data out
    input wire logic                       o_avs_waitrequest, // stall
    input wire logic                       i_addr_nak,        // event
    input wire logic                       o_irq              // irq
);
    logic [31:0] mask_ff;
    wire         rd_ok = i_avs_read && !o_avs_waitrequest;
    wire         wr_ok = i_avs_write && !o_avs_waitrequest;
    wire  [31:0] lane_d = i_avs_writedata & {{8{i_avs_byteenable[3]}},
        {8{i_avs_byteenable[2]}}, {8{i_avs_byteenable[1]}},
        {8{i_avs_byteenable[0]}}};
    // mask shadow, moved only at the edge where a write lands
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) mask_ff <= RST_ZERO;
        else if (wr_ok && i_avs_address == OFS_IRQ_SET)
            mask_ff <= mask_ff | (lane_d & MASK_BITS);
        else if (wr_ok && i_avs_address == OFS_IRQ_CLR)
            mask_ff <= mask_ff & ~lane_d;
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    a_answer_next: assert property ((i_avs_read || i_avs_write) &&
        o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
    a_wait_single: assert property (!o_avs_waitrequest |=>
        o_avs_waitrequest) else $error("answer held too long");
    a_reset_quiet: assert property ($fell(i_rst) |-> o_irq == 1'b0)
        else $error("irq up after reset");
    a_mask_read: assert property (rd_ok && i_avs_address == OFS_IRQ_MASK
        |-> o_avs_readdata == mask_ff) else $error("mask read wrong");
    a_params_zero: assert property (rd_ok && i_avs_address == OFS_PARAMS
        |-> o_avs_readdata == PARAMS_VALUE) else $error("params not 0");
    a_status_rsvd: assert property (rd_ok && i_avs_address == OFS_STATUS
        |-> (o_avs_readdata & ~(MASK_BITS | 32'h0001_0000)) == RST_ZERO)
        else $error("reserved status bit set");
    a_irq_masked: assert property (mask_ff == RST_ZERO |-> !o_irq)
        else $error("irq with empty mask");
    a_event_irq: assert property (i_addr_nak && mask_ff[B_ADDR_NAK] &&
        !wr_ok |=> o_irq) else $error("event gave no irq");
    c_mask: cover property (rd_ok && i_avs_address == OFS_IRQ_MASK &&
        mask_ff != RST_ZERO);
    c_event: cover property (i_addr_nak ##1 o_irq);
    c_drop: cover property (o_irq ##1 !o_irq);
endmodule : tws_status_sva
bind tws_master_status tws_status_sva u_sva (.i_core_clk, .i_rst,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .i_addr_nak, .o_irq);

// file: tb/tws_bus_model.sv
// Purpose: slave side of the two-wire bus for the status bench
// Assumes: open-drain lines with pull-ups, 125 ns link clock
// Notes:   clock stands high between frames, never free running
`timescale 1ns/1ps
module tws_bus_model (
    output logic o_scl, // clock line
    output logic o_sda  // data line
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // released lines float up through the pull-ups
    assign o_scl = !scl_low;
    assign o_sda = !sda_low;
    // start or stop: data moves while the clock is high
    task automatic frame_edge(input logic stop);
        sda_low = 1'b1;
        #62.5 scl_low = !stop;
        #62.5 sda_low = !stop;
    endtask : frame_edge
    // one bit, set up while low, held while the clock is high
    task automatic send_bit(input logic b);
        sda_low = !b;
        #62.5 scl_low = 1'b0;
        #62.5 scl_low = 1'b1;
    endtask : send_bit
endmodule : tws_bus_model

// file: tb/tws_master_status_tb.sv
// Purpose: self-checking bench for the status and irq block
// Assumes: one bus request in flight at a time
// Notes:   read results are noted in a queue and matched on return
`timescale 1ns/1ps
module tws_master_status_tb;
    import tws_pkg::*;
    localparam logic [11:0] VER = 12'h5A1; // arbitrary value
    localparam logic [3:0]  VAR = 4'h6;    // arbitrary value
    localparam int EB [7] = '{B_ADDR_NAK, B_DATA_NAK, B_CMD_DONE,
        B_STOP_ACC, B_TIMEOUT, B_PEC_ERR, B_ALERT};
    logic        clk = 0, rst = 1, rd_en = 0, wr_en = 0, irq, wait_rq;
    logic        men = 0, own = 0, drv = 0, bfree = 1, scl, sda;
    logic [5:0]  addr = 0;
    logic [3:0]  be = 4'hF;
    logic [6:0]  ev = 0;
    logic [4:0]  lv = 0;
    logic [31:0] wdata = 0, rdata, emask = 0, b, r;
    logic [31:0] exp_q [$];
    int          fail_count = 0, check_count = 0, i, k;
    always #5 clk = ~clk;
    tws_bus_model bm (.o_scl(scl), .o_sda(sda));
    tws_master_status #(.VERSION_NUM(VER), .VARIANT_NUM(VAR)) uut (
        .i_core_clk(clk), .i_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_rq), .i_scl_pin(scl),
        .i_sda_pin(sda & ~drv), .i_sda_drive_low(drv), .i_bus_owner(own),
        .i_master_en(men), .i_addr_nak(ev[0]), .i_data_nak(ev[1]),
        .i_cmd_ok(ev[2]), .i_stop_acc(ev[3]), .i_timeout(ev[4]),
        .i_pec_err(ev[5]), .i_alert(ev[6]), .i_cmd_busy(lv[0]),
        .i_cmd_valid(lv[0]), .i_ncmd_valid(lv[1]), .i_tx_full(lv[2]),
        .i_tx_stopped(lv[3]), .i_rx_avail(lv[4]), .o_irq(irq));
    task automatic conclude();
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED readdata expected %h seen %h", e, g);
        end
    endtask : cmp_word
    // irq is looked at mid-cycle, once the last edge has settled
    task automatic cmp_irq(input logic e);
        @(negedge clk);
        check_count++;
        if (irq !== e) begin
            fail_count++;
            $display("CHECK FAILED irq expected %b seen %b", e, irq);
        end
    endtask : cmp_irq
    // avalon request held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        rd_en <= rd;
        wr_en <= !rd;
        addr <= a;
        wdata <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wait_rq === 1'b0) break;
        end
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (n == 20) begin
            fail_count++;
            conclude();
        end
    endtask : bus
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, RST_ZERO);
    endtask : rd_chk
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask : wr
    task automatic pulse(input int n);
        @(posedge clk);
        ev[n] <= 1'b1;
        @(posedge clk);
        ev <= 7'h00;
    endtask : pulse
    // level part of the status word from the present inputs
    function automatic logic [31:0] lvl();
        lvl = {15'h0000, men, 10'h000, bfree, !lv[0] && !lv[1], 1'b0,
               !(lv[0] && lv[1]), !lv[2] && !lv[3], lv[4]};
    endfunction : lvl
    // each completed read takes the oldest note
    always @(posedge clk) begin
        if (rd_en && wait_rq === 1'b0 && exp_q.size() > 0)
            cmp_word(exp_q.pop_front(), rdata);
    end
    initial begin
        r = $urandom(63068);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_IRQ_MASK, RST_ZERO);
        rd_chk(OFS_PARAMS, PARAMS_VALUE);
        rd_chk(OFS_REVISION, {12'h000, VAR, 4'h0, VER});
        for (i = 0; i < 8; i++) begin
            lv <= 5'($urandom);
            men <= 1'($urandom);
            repeat (3) @(posedge clk);
            rd_chk(OFS_STATUS, lvl());
        end
        for (i = 0; i < 6; i++) begin
            // random lanes too: disabled lanes must leave the mask alone
            r = $urandom;
            k = $urandom;
            be <= k[3:0];
            wr(i[0] ? OFS_IRQ_CLR : OFS_IRQ_SET, r);
            b = {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}} & r;
            emask = i[0] ? emask & ~b : emask | (b & MASK_BITS);
            rd_chk(OFS_IRQ_MASK, emask);
        end
        be <= 4'hF;
        wr(6'h3C, $urandom);
        rd_chk(6'h3C, RST_ZERO);
        rd_chk(OFS_IRQ_MASK, emask);
        wr(OFS_IRQ_CLR, 32'hFFFF_FFFF);
        cmp_irq(1'b0);
        // every sticky event except arbitration lost: raise, mask off and on, clear
        for (k = 0; k < 7; k++) begin
            b = 32'h1 << EB[k];
            wr(OFS_IRQ_SET, b);
            pulse(k);
            @(posedge clk);
            cmp_irq(1'b1);
            rd_chk(OFS_STATUS, lvl() | b);
            wr(OFS_IRQ_CLR, b);
            cmp_irq(1'b0);
            wr(OFS_IRQ_SET, b);
            cmp_irq(1'b1);
            wr(OFS_STAT_CLR, CLEARABLE_BITS & ~b);
            cmp_irq(1'b1);
            wr(OFS_STAT_CLR, b);
            cmp_irq(1'b0);
            rd_chk(OFS_STATUS, lvl());
            wr(OFS_IRQ_CLR, b);
        end
        // frame with a lost bit: the line reads low while released
        bm.frame_edge(1'b0);
        bfree = 1'b0;
        rd_chk(OFS_STATUS, lvl());
        wr(OFS_IRQ_SET, 32'h1 << B_ARB_LOST);
        own <= 1'b1;
        bm.send_bit(1'b1);
        @(posedge clk);
        drv <= 1'b1;
        bm.send_bit(1'b0);
        repeat (4) @(posedge clk);
        cmp_irq(1'b0);
        drv <= 1'b0;
        bm.send_bit(1'b0);
        repeat (4) @(posedge clk);
        cmp_irq(1'b1);
        own <= 1'b0;
        bm.frame_edge(1'b1);
        bfree = 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(OFS_STATUS, lvl() | 32'h1 << B_ARB_LOST);
        wr(OFS_STAT_CLR, 32'h1 << B_ARB_LOST);
        cmp_irq(1'b0);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule : tws_master_status_tb
